// >>> inc/aprt_pkg.sv
// package for the audio port router: register indices, field layout,
// reset values and selector codes.
// assumes: included ahead of logic/aprt_router.sv in compile order.
package aprt_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] APRT_IDX_P12_CLKPAIR = 10'h065;
    localparam logic [9:0] APRT_IDX_P12_DATA = 10'h066;
    localparam logic [9:0] APRT_IDX_P12_SYSCLK = 10'h067;
    localparam logic [9:0] APRT_IDX_P34_CLKPAIR = 10'h068;
    localparam logic [9:0] APRT_IDX_P34_DATA = 10'h069;
    localparam logic [9:0] APRT_IDX_P34_SYSCLK = 10'h06A;

    // ------------------------------------------------------------
    // field layout: odd port in the low field, even port in the high
    // ------------------------------------------------------------
    localparam int APRT_LO_FIELD_POS = 0;
    localparam int APRT_HI_FIELD_POS = 4;
    localparam logic [7:0] APRT_SYSCLK_WMASK = 8'h77;

    // ------------------------------------------------------------
    // reset values, port 1..4
    // ------------------------------------------------------------
    localparam logic [3:0] APRT_P1_CLKPAIR_RST = 4'h0;
    localparam logic [3:0] APRT_P2_CLKPAIR_RST = 4'h1;
    localparam logic [3:0] APRT_P3_CLKPAIR_RST = 4'h2;
    localparam logic [3:0] APRT_P4_CLKPAIR_RST = 4'h3;
    localparam logic [3:0] APRT_P1_DATA_RST = 4'h0;
    localparam logic [3:0] APRT_P2_DATA_RST = 4'h1;
    localparam logic [3:0] APRT_P3_DATA_RST = 4'h2;
    localparam logic [3:0] APRT_P4_DATA_RST = 4'h3;
    localparam logic [2:0] APRT_P1_SYSCLK_RST = 3'h0;
    localparam logic [2:0] APRT_P2_SYSCLK_RST = 3'h1;
    localparam logic [2:0] APRT_P3_SYSCLK_RST = 3'h2;
    localparam logic [2:0] APRT_P4_SYSCLK_RST = 3'h3;

    // ------------------------------------------------------------
    // selector codes beyond the port codes 0..5
    // ------------------------------------------------------------
    localparam logic [3:0] APRT_SEL_LAST_PORT = 4'h5;
    localparam logic [3:0] APRT_CLK_DAC_A = 4'h6;
    localparam logic [3:0] APRT_CLK_DAC_B = 4'h7;
    localparam logic [3:0] APRT_CLK_ADC_A = 4'h8;
    localparam logic [3:0] APRT_CLK_ADC_B = 4'h9;
    localparam logic [3:0] APRT_DAT_GPIN_ONE = 4'h6;
    localparam logic [3:0] APRT_DAT_GPIN_TWO = 4'h7;
    localparam logic [3:0] APRT_DAT_ADC_A = 4'h8;
    localparam logic [3:0] APRT_DAT_ADC_B = 4'h9;
    localparam logic [2:0] APRT_SCK_LAST_PORT = 3'h5;

    // number of routed ports and of ports that can act as sources
    localparam int APRT_NUM_ROUTED = 4;
    localparam int APRT_NUM_SOURCES = 6;

endpackage

// >>> logic/aprt_router.sv
// audio port router for ports 1 to 4: six selector registers on apb and
// the routing of clock pairs, serial data and system clocks to the pins.
// assumes: pin inputs are asynchronous to clk; converter master clocks and
// adc data come from on-chip logic clocked by clk.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

// What this block does
// - clock pair codes 0-5 route other port clocks
// - codes 6-9 route converter master clock pairs
// - port 1 clock pair resets to input
// - port 2 clock pair resets to input
// - port 3 clock pair resets to input
// - port 4 clock pair resets to input
// - data codes 0-5 route other port data
// - data codes 8,9 route adc data
// - port 1 data resets to input
// - port 2 data resets to input
// - port 3 data resets to input
// - port 4 data resets to input
// - sysclk codes 0-5 route other port sysclks
// - port 1 sysclk resets to input
// - port 2 sysclk resets to input
// - port 3 sysclk resets to input
// - port 4 sysclk resets to input
// - ports 1-2 selectors at 65h-67h, even high
// - ports 3-4 selectors at 68h-6Ah, port 4 high
// - master converters drive their own clock pairs
module aprt_router
    import aprt_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // received pin levels, index 0..5 is port 1..6
    input wire logic [5:0] port_frame_clock_in,
    input wire logic [5:0] port_bit_clock_in,
    input wire logic [5:0] port_data_in,
    input wire logic [5:0] port_sysclk_in,
    input wire logic general_pin_one,
    input wire logic general_pin_two,
    // master mode clock pairs and adc serial data, on-chip
    input wire logic dac_pair_a_frame_clock,
    input wire logic dac_pair_a_bit_clock,
    input wire logic dac_pair_b_frame_clock,
    input wire logic dac_pair_b_bit_clock,
    input wire logic adc_pair_a_frame_clock,
    input wire logic adc_pair_a_bit_clock,
    input wire logic adc_pair_b_frame_clock,
    input wire logic adc_pair_b_bit_clock,
    input wire logic adc_pair_a_data,
    input wire logic adc_pair_b_data,
    // pin drivers for ports 1..4, index 0..3
    output logic [3:0] port_frame_clock_out,
    output logic [3:0] port_bit_clock_out,
    output logic [3:0] port_clkpair_oe,
    output logic [3:0] port_data_out,
    output logic [3:0] port_data_oe,
    output logic [3:0] port_sysclk_out,
    output logic [3:0] port_sysclk_oe
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 4 * APRT_NUM_SOURCES + 2;

    logic [SYNC_W-1:0] pin_meta_q;
    logic [SYNC_W-1:0] pin_sync_q;
    logic [5:0] fclk_s;
    logic [5:0] bclk_s;
    logic [5:0] data_s;
    logic [5:0] sck_s;
    logic gpin1_s;
    logic gpin2_s;

    // the first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {general_pin_two, general_pin_one, port_sysclk_in,
                           port_data_in, port_bit_clock_in,
                           port_frame_clock_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign fclk_s = pin_sync_q[5:0];
    assign bclk_s = pin_sync_q[11:6];
    assign data_s = pin_sync_q[17:12];
    assign sck_s = pin_sync_q[23:18];
    assign gpin1_s = pin_sync_q[24];
    assign gpin2_s = pin_sync_q[25];

    // ------------------------------------------------------------
    // selector registers
    // ------------------------------------------------------------
    logic [7:0] p12_clkpair_q;
    logic [7:0] p12_data_q;
    logic [6:0] p12_sysclk_q;
    logic [7:0] p34_clkpair_q;
    logic [7:0] p34_data_q;
    logic [6:0] p34_sysclk_q;

    logic [9:0] reg_idx;
    logic addr_ok;
    logic wr_en;
    logic [7:0] wbyte;

    assign reg_idx = paddr[11:2];
    assign wbyte = pwdata[7:0];
    assign wr_en = psel && penable && pready && pwrite && addr_ok && pstrb[0];

    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx >= APRT_IDX_P12_CLKPAIR) &&
                     (idx <= APRT_IDX_P34_SYSCLK);
    endfunction

    assign addr_ok = idx_mapped(reg_idx) && (paddr[1:0] == 2'b00);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p12_clkpair_q <= {APRT_P2_CLKPAIR_RST, APRT_P1_CLKPAIR_RST};
            p34_clkpair_q <= {APRT_P4_CLKPAIR_RST, APRT_P3_CLKPAIR_RST};
        end else if (wr_en && reg_idx == APRT_IDX_P12_CLKPAIR) begin
            p12_clkpair_q <= wbyte;
        end else if (wr_en && reg_idx == APRT_IDX_P34_CLKPAIR) begin
            p34_clkpair_q <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p12_data_q <= {APRT_P2_DATA_RST, APRT_P1_DATA_RST};
            p34_data_q <= {APRT_P4_DATA_RST, APRT_P3_DATA_RST};
        end else if (wr_en && reg_idx == APRT_IDX_P12_DATA) begin
            p12_data_q <= wbyte;
        end else if (wr_en && reg_idx == APRT_IDX_P34_DATA) begin
            p34_data_q <= wbyte;
        end
    end

    // bits 7 and 3 are reserved: bit 7 not stored, bit 3 stored but masked on write; both read as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p12_sysclk_q <= {APRT_P2_SYSCLK_RST, 1'b0, APRT_P1_SYSCLK_RST};
            p34_sysclk_q <= {APRT_P4_SYSCLK_RST, 1'b0, APRT_P3_SYSCLK_RST};
        end else if (wr_en && reg_idx == APRT_IDX_P12_SYSCLK) begin
            p12_sysclk_q <= wbyte[6:0] & APRT_SYSCLK_WMASK[6:0];
        end else if (wr_en && reg_idx == APRT_IDX_P34_SYSCLK) begin
            p34_sysclk_q <= wbyte[6:0] & APRT_SYSCLK_WMASK[6:0];
        end
    end

    // ------------------------------------------------------------
    // apb answer: one access cycle, no wait states
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (reg_idx)
            APRT_IDX_P12_CLKPAIR: rd_byte = p12_clkpair_q;
            APRT_IDX_P12_DATA: rd_byte = p12_data_q;
            APRT_IDX_P12_SYSCLK: rd_byte = {1'b0, p12_sysclk_q};
            APRT_IDX_P34_CLKPAIR: rd_byte = p34_clkpair_q;
            APRT_IDX_P34_DATA: rd_byte = p34_data_q;
            APRT_IDX_P34_SYSCLK: rd_byte = {1'b0, p34_sysclk_q};
            default: rd_byte = 8'h00;
        endcase
    end

    // pready is registered from the setup cycle, so it is high in the first access cycle and the access completes at once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (psel && !penable && !pwrite && addr_ok) begin
                prdata <= {24'h00_0000, rd_byte};
            end else if (psel && !penable) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // routing
    // ------------------------------------------------------------
    logic [3:0] clk_sel [4];
    logic [3:0] dat_sel [4];
    logic [2:0] sck_sel [4];

    assign clk_sel[0] = p12_clkpair_q[APRT_LO_FIELD_POS +: 4];
    assign clk_sel[1] = p12_clkpair_q[APRT_HI_FIELD_POS +: 4];
    assign clk_sel[2] = p34_clkpair_q[APRT_LO_FIELD_POS +: 4];
    assign clk_sel[3] = p34_clkpair_q[APRT_HI_FIELD_POS +: 4];
    assign dat_sel[0] = p12_data_q[APRT_LO_FIELD_POS +: 4];
    assign dat_sel[1] = p12_data_q[APRT_HI_FIELD_POS +: 4];
    assign dat_sel[2] = p34_data_q[APRT_LO_FIELD_POS +: 4];
    assign dat_sel[3] = p34_data_q[APRT_HI_FIELD_POS +: 4];
    assign sck_sel[0] = p12_sysclk_q[APRT_LO_FIELD_POS +: 3];
    assign sck_sel[1] = p12_sysclk_q[APRT_HI_FIELD_POS +: 3];
    assign sck_sel[2] = p34_sysclk_q[APRT_LO_FIELD_POS +: 3];
    assign sck_sel[3] = p34_sysclk_q[APRT_HI_FIELD_POS +: 3];

    // returns {enable, frame, bit}
    function automatic logic [2:0] route_clkpair(
        input logic [3:0] sel, input logic [3:0] own,
        input logic [5:0] fc, input logic [5:0] bc,
        input logic [3:0] mf, input logic [3:0] mb);
        route_clkpair = 3'b000;
        if (sel == own) begin
            route_clkpair = 3'b000;
        end else if (sel <= APRT_SEL_LAST_PORT) begin
            route_clkpair = {1'b1, fc[sel[2:0]], bc[sel[2:0]]};
        end else if (sel <= APRT_CLK_ADC_B) begin
            // master converters make their own pair from the sysclk
            route_clkpair = {1'b1, mf[sel[1:0] - 2'd2],
                             mb[sel[1:0] - 2'd2]};
        end else begin
            route_clkpair = 3'b000;
        end
    endfunction

    // returns {enable, data}
    function automatic logic [1:0] route_data(
        input logic [3:0] sel, input logic [3:0] own,
        input logic [5:0] dt, input logic g1, input logic g2,
        input logic a1, input logic a2);
        route_data = 2'b00;
        if (sel == own) begin
            route_data = 2'b00;
        end else if (sel <= APRT_SEL_LAST_PORT) begin
            route_data = {1'b1, dt[sel[2:0]]};
        end else if (sel == APRT_DAT_GPIN_ONE) begin
            route_data = {1'b1, g1};
        end else if (sel == APRT_DAT_GPIN_TWO) begin
            route_data = {1'b1, g2};
        end else if (sel == APRT_DAT_ADC_A) begin
            route_data = {1'b1, a1};
        end else if (sel == APRT_DAT_ADC_B) begin
            route_data = {1'b1, a2};
        end else begin
            route_data = 2'b00;
        end
    endfunction

    // returns {enable, sysclk}
    function automatic logic [1:0] route_sck(
        input logic [2:0] sel, input logic [2:0] own, input logic [5:0] sc);
        route_sck = 2'b00;
        if (sel == own) begin
            route_sck = 2'b00;
        end else if (sel <= APRT_SCK_LAST_PORT) begin
            route_sck = {1'b1, sc[sel]};
        end else begin
            route_sck = 2'b00;
        end
    endfunction

    logic [3:0] mst_fclk;
    logic [3:0] mst_bclk;

    assign mst_fclk = {adc_pair_b_frame_clock, adc_pair_a_frame_clock,
                       dac_pair_b_frame_clock, dac_pair_a_frame_clock};
    assign mst_bclk = {adc_pair_b_bit_clock, adc_pair_a_bit_clock,
                       dac_pair_b_bit_clock, dac_pair_a_bit_clock};

    // one register stage on every pin output; the routed clocks are
    // resampled at 125 MHz, so their edges move by up to one clk period
    for (genvar p = 0; p < APRT_NUM_ROUTED; p++) begin : g_port
        logic [2:0] clk_r;
        logic [1:0] dat_r;
        logic [1:0] sck_r;

        assign clk_r = route_clkpair(clk_sel[p], 4'(p), fclk_s, bclk_s,
                                     mst_fclk, mst_bclk);
        assign dat_r = route_data(dat_sel[p], 4'(p), data_s, gpin1_s,
                                  gpin2_s, adc_pair_a_data, adc_pair_b_data);
        assign sck_r = route_sck(sck_sel[p], 3'(p), sck_s);

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                port_clkpair_oe[p] <= 1'b0;
                port_frame_clock_out[p] <= 1'b0;
                port_bit_clock_out[p] <= 1'b0;
            end else begin
                port_clkpair_oe[p] <= clk_r[2];
                port_frame_clock_out[p] <= clk_r[1] & clk_r[2];
                port_bit_clock_out[p] <= clk_r[0] & clk_r[2];
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                port_data_oe[p] <= 1'b0;
                port_data_out[p] <= 1'b0;
            end else begin
                port_data_oe[p] <= dat_r[1];
                port_data_out[p] <= dat_r[0] & dat_r[1];
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                port_sysclk_oe[p] <= 1'b0;
                port_sysclk_out[p] <= 1'b0;
            end else begin
                port_sysclk_oe[p] <= sck_r[1];
                port_sysclk_out[p] <= sck_r[0] & sck_r[1];
            end
        end
    end

endmodule

// >>> tb/aprt_far_end.sv
// far-end audio devices on ports 1 to 6.
// assumes: run lets the 160 ns bit clock toggle; pat sets the idle levels.
`timescale 1ns/1ps
module aprt_far_end (
    input wire logic run,
    input wire logic [5:0] pat,
    output logic [5:0] port_frame_clock_in,
    output logic [5:0] port_bit_clock_in,
    output logic [5:0] port_data_in,
    output logic [5:0] port_sysclk_in,
    output logic general_pin_one,
    output logic general_pin_two
);
    logic bit_clock;
    logic [2:0] cnt;
    // bit clock toggles every 80 ns without pause while run is high
    initial begin
        bit_clock = 1'b0;
        cnt = 3'h0;
        forever begin
            #80;
            bit_clock = run ? ~bit_clock : 1'b0;
            cnt = !run ? 3'h0 : bit_clock ? cnt : cnt + 3'h1;
        end
    end
    assign port_bit_clock_in = run ? {6{bit_clock}} : ~pat;
    assign port_frame_clock_in = run ? {6{cnt[2]}} : pat;
    assign port_data_in = run ? pat ^ {6{cnt[0]}} : pat ^ 6'h15;
    assign port_sysclk_in = pat ^ 6'h2A;
    assign general_pin_one = ~pat[0];
    assign general_pin_two = pat[1];
endmodule

// >>> tb/aprt_router_monitor.sv
// checker for the audio port router: apb answers, reset state, pin gating.
// assumes: bound to aprt_router; one clock domain, nrst active low.
`timescale 1ns/1ps
module aprt_router_monitor
    import aprt_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] port_frame_clock_out,
    input wire logic [3:0] port_bit_clock_out,
    input wire logic [3:0] port_clkpair_oe,
    input wire logic [3:0] port_data_out,
    input wire logic [3:0] port_data_oe,
    input wire logic [3:0] port_sysclk_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wr_q;
    // a pin may only start or stop driving after a completed write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= psel && penable && pwrite && pready;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    property p_rdy;
        s_setup |=> pready;
    endproperty
    property p_unmapped;
        pready && (paddr[11:2] < APRT_IDX_P12_CLKPAIR ||
            paddr[11:2] > APRT_IDX_P34_SYSCLK) |-> pslverr && prdata == 0;
    endproperty
    property p_err_pair;
        pslverr |-> pready;
    endproperty
    property p_rst_clk;
        $rose(nrst) |-> port_clkpair_oe == 4'h0;
    endproperty
    property p_rst_dat;
        $rose(nrst) |-> port_data_oe == 4'h0;
    endproperty
    property p_rst_sck;
        $rose(nrst) |-> port_sysclk_oe == 4'h0;
    endproperty
    property p_gate_clk;
        ((port_frame_clock_out | port_bit_clock_out) & ~port_clkpair_oe) == 0;
    endproperty
    property p_gate_dat;
        (port_data_out & ~port_data_oe) == 4'h0;
    endproperty
    property p_rsv_read;
        pready && !pslverr && paddr[11:2] == APRT_IDX_P12_SYSCLK
            |-> prdata[7] == 1'b0 && prdata[3] == 1'b0;
    endproperty
    property p_oe_cause;
        $changed({port_clkpair_oe, port_data_oe, port_sysclk_oe}) |-> $past(wr_q);
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
    a_err_pair: assert property (p_err_pair) else $error("lone error");
    a_rst_clk: assert property (p_rst_clk) else $error("clk oe at reset");
    a_rst_dat: assert property (p_rst_dat) else $error("data oe at reset");
    a_rst_sck: assert property (p_rst_sck) else $error("sck oe at reset");
    a_gate_clk: assert property (p_gate_clk) else $error("clk undriven");
    a_gate_dat: assert property (p_gate_dat) else $error("data undriven");
    a_rsv_read: assert property (p_rsv_read) else $error("reserved bit");
    a_oe_cause: assert property (p_oe_cause) else $error("oe no write");
endmodule

bind aprt_router aprt_router_monitor u_mon (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_frame_clock_out(port_frame_clock_out),
    .port_bit_clock_out(port_bit_clock_out),
    .port_clkpair_oe(port_clkpair_oe), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .port_sysclk_oe(port_sysclk_oe));

// >>> tb/aprt_router_tb.sv
// self-checking bench for the audio port router.
// assumes: far-end model on the pins; bench is the apb master.
`timescale 1ns/1ps
module aprt_router_tb;
    import aprt_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, run, g1, g2, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, fo, bo, co, dto, dtoe, so, soe, mfc, mbc;
    logic [5:0] fci, bci, dti, sci, pat;
    logic [1:0] adt;
    int fails, tests_run;
    aprt_router dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_frame_clock_in(fci), .port_bit_clock_in(bci),
        .port_data_in(dti), .port_sysclk_in(sci), .general_pin_one(g1),
        .general_pin_two(g2), .dac_pair_a_frame_clock(mfc[0]),
        .dac_pair_a_bit_clock(mbc[0]), .dac_pair_b_frame_clock(mfc[1]),
        .dac_pair_b_bit_clock(mbc[1]), .adc_pair_a_frame_clock(mfc[2]),
        .adc_pair_a_bit_clock(mbc[2]), .adc_pair_b_frame_clock(mfc[3]),
        .adc_pair_b_bit_clock(mbc[3]), .adc_pair_a_data(adt[0]),
        .adc_pair_b_data(adt[1]), .port_frame_clock_out(fo),
        .port_bit_clock_out(bo), .port_clkpair_oe(co), .port_data_out(dto),
        .port_data_oe(dtoe), .port_sysclk_out(so), .port_sysclk_oe(soe));
    aprt_far_end far (.run(run), .pat(pat), .port_frame_clock_in(fci),
        .port_bit_clock_in(bci), .port_data_in(dti), .port_sysclk_in(sci),
        .general_pin_one(g1), .general_pin_two(g2));
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [9:0] idx, input logic [1:0] lo,
        input logic w, input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= {idx, lo};
        pwrite <= w;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic put(input logic [9:0] idx, input logic [7:0] d);
        apb(idx, 2'b00, 1'b1, d, 4'hF);
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_regs();
        logic [7:0] ex [6] = '{8'h10, 8'h10, 8'h10, 8'h32, 8'h32, 8'h32};
        chk({co, dtoe, soe}, 0);
        for (int i = 0; i < 6; i++) begin
            apb(APRT_IDX_P12_CLKPAIR + 10'(i), 2'b00, 1'b0, 8'h00, 4'h0);
            chk(rd, {24'h0, ex[i]});
        end
        apb(APRT_IDX_P12_DATA, 2'b00, 1'b1, 8'h55, 4'hE);
        apb(APRT_IDX_P12_DATA, 2'b00, 1'b0, 8'h00, 4'h0);
        chk(rd, 32'h10);
        apb(10'h064, 2'b00, 1'b0, 8'h00, 4'h0);
        chk({er, rd[7:0]}, 9'h100);
        apb(APRT_IDX_P12_DATA, 2'b01, 1'b0, 8'h00, 4'h0);
        chk(er, 1);
    endtask
    task automatic t_route();
        logic [3:0] c;
        logic e;
        for (int i = 0; i < 11; i++) begin
            c = 4'(i);
            put(APRT_IDX_P12_CLKPAIR, {c, 4'h0});
            e = c != 4'h1 && c < 4'hA;
            chk({co[1], fo[1], bo[1]}, e ? {1'b1, {mfc, fci}[c],
                {mbc, bci}[c]} : 3'h0);
            put(APRT_IDX_P34_DATA, {4'h3, c});
            e = c != 4'h2 && c < 4'hA;
            chk({dtoe[2], dto[2]}, e ? {1'b1,
                {adt, g2, g1, dti}[c]} : 2'h0);
            put(APRT_IDX_P34_SYSCLK, {1'b0, c[2:0], 4'h2});
            e = c[2:0] != 3'h3 && c[2:0] < 3'h6;
            chk({soe[3], so[3]}, e ? {1'b1, sci[c[2:0]]} : 2'h0);
        end
        put(APRT_IDX_P34_SYSCLK, 8'hFF);
        apb(APRT_IDX_P34_SYSCLK, 2'b00, 1'b0, 8'h00, 4'h0);
        chk(rd, 32'h77);
        put(APRT_IDX_P34_SYSCLK, 8'h32);
        put(APRT_IDX_P34_DATA, 8'h32);
    endtask
    task automatic t_link();
        int n;
        run <= 1'b1;
        put(APRT_IDX_P12_CLKPAIR, 8'h11);
        n = 0;
        for (int i = 0; i < 100; i++) begin
            e_wait();
            n += int'(bo[0] != bi_prev);
        end
        chk(n >= 9 && n <= 11, 1);
        run <= 1'b0;
        put(APRT_IDX_P12_CLKPAIR, 8'h10);
    endtask
    logic bi_prev;
    task automatic e_wait();
        bi_prev = bo[0];
        @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #60000;
        fails++;
        wrap_up();
    end
    initial begin
        {nrst, psel, penable, pwrite, run, paddr, pwdata, pstrb} = 0;
        pat = 6'b100100;
        mfc = 4'b1010;
        mbc = 4'b0110;
        adt = 2'b01;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        t_regs();
        t_route();
        t_link();
        wrap_up();
    end
endmodule
